// file: logic/pwmg_top.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwmg_top
   import pwmg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [1:0]  avs_response,
   input  wire logic        adc_irq,
   output logic             wave_out,
   output logic             shared_irq_line
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pwmg_ctrl_t  ctrl;
      logic [15:0] period_value;   // live period
      logic [15:0] duty_value;     // programmed duty
      logic [15:0] duty_shadow;    // compared duty
      logic [7:0]  period_lo_buf;
      logic [15:0] duty_buf;
      logic [15:0] cycle_counter;
      logic        wave;
      logic [7:0]  irq_mask;
      logic        acked;
      logic [31:0] rdata;
      logic [1:0]  resp;
   } pwmg_state_t;

   pwmg_state_t   st;
   pwmg_state_t   next_st;
   pwmg_bus_req_t req;
   logic          tick;
   logic          reload;
   logic          flag;
   logic          pwm_irq;
   logic          wr_hit;
   logic          flag_clear;
   logic          lane0;
   logic [7:0]    wbyte;
   logic          cmp_hi;

   assign req.read      = avs_read;
   assign req.write     = avs_write;
   assign req.address   = avs_address;
   assign req.writedata = avs_writedata;
   assign lane0         = avs_byteenable[0];
   assign wbyte         = req.writedata[7:0];

   // ----------------------------------------------------------------
   // Prescaler and interrupt flag
   // ----------------------------------------------------------------
   pwmg_prescaler u_ps (
      .clk        (clk),
      .nrst       (nrst),
      .run        (st.ctrl.unit_enable),
      .divide_sel (st.ctrl.prescale_select),
      .tick       (tick)
   );

   // Writes land only at the edge that sees waitrequest low
   assign wr_hit     = req.write && st.acked && lane0;
   assign flag_clear = wr_hit && req.address == ADDR_CONTROL
                       && wbyte[BIT_FLAG];
   assign reload     = tick && st.cycle_counter >= st.period_value;

   pwmg_irq u_irq (
      .clk      (clk),
      .nrst     (nrst),
      .event_in (reload),
      .clear_in (flag_clear),
      .gate_in  (st.ctrl.irq_enable && st.irq_mask[BIT_FLAG]),
      .flag     (flag),
      .irq      (pwm_irq)
   );

   // Shared line: converter request or ours
   assign shared_irq_line = pwm_irq | adc_irq;

   // Normal compare result: high at or above duty
   assign cmp_hi = st.cycle_counter >= st.duty_shadow;

   // ----------------------------------------------------------------
   // Bus slave: one wait cycle, answer on second edge
   // ----------------------------------------------------------------
   assign avs_waitrequest = (req.read || req.write) && !st.acked;
   assign avs_readdata    = st.rdata;
   assign avs_response    = st.resp;
   assign wave_out        = st.wave;

   always_comb begin
      next_st = st;
      next_st.acked = (req.read || req.write) && !st.acked;

      // Counter advance and reload
      if (!st.ctrl.unit_enable) begin
         next_st.cycle_counter = RESET_WORD;
      end else if (reload) begin
         next_st.cycle_counter = RESET_WORD;
         next_st.duty_shadow   = st.duty_value;
      end else if (tick) begin
         next_st.cycle_counter = st.cycle_counter + 16'h0001;
      end

      // Output stage
      if (st.ctrl.unit_enable) begin
         next_st.wave = cmp_hi ^ st.ctrl.output_polarity;
      end else begin
         next_st.wave = st.ctrl.idle_level;
      end

      // Register writes
      if (wr_hit) begin
         unique case (req.address)
            ADDR_CONTROL: begin
               next_st.ctrl.unit_enable     = wbyte[BIT_ENABLE];
               next_st.ctrl.prescale_select = wbyte[BIT_PS_HI:BIT_PS_LO];
               next_st.ctrl.idle_level      = wbyte[BIT_IDLE];
               next_st.ctrl.irq_enable      = wbyte[BIT_IRQ_EN];
               next_st.ctrl.output_polarity = wbyte[BIT_POLARITY];
            end
            ADDR_PERIOD_HI: begin
               // Commit all buffered bytes at once
               next_st.period_value = {wbyte, st.period_lo_buf};
               next_st.duty_value   = st.duty_buf;
            end
            ADDR_PERIOD_LO: next_st.period_lo_buf  = wbyte;
            ADDR_DUTY_HI:   next_st.duty_buf[15:8] = wbyte;
            ADDR_DUTY_LO:   next_st.duty_buf[7:0]  = wbyte;
            ADDR_IRQ_MASK:  next_st.irq_mask       = wbyte;
            default: ;
         endcase
      end

      // Read data and response, registered on the edge that sees waitrequest high
      if ((req.read || req.write) && !st.acked) begin
         next_st.resp  = 2'h0;
         next_st.rdata = 32'h0000_0000;
         unique case (req.address)
            ADDR_CONTROL:   next_st.rdata[7:0] = {st.ctrl.unit_enable,
                               st.ctrl.prescale_select, st.ctrl.idle_level,
                               st.ctrl.irq_enable, st.ctrl.output_polarity,
                               flag};
            ADDR_PERIOD_HI: next_st.rdata[7:0] = st.period_value[15:8];
            ADDR_PERIOD_LO: next_st.rdata[7:0] = st.period_value[7:0];
            ADDR_DUTY_HI:   next_st.rdata[7:0] = st.duty_value[15:8];
            ADDR_DUTY_LO:   next_st.rdata[7:0] = st.duty_value[7:0];
            ADDR_IRQ_MASK:  next_st.rdata[7:0] = st.irq_mask;
            default:        next_st.resp = 2'h2;   // Unmapped: slave error
         endcase
         if (!req.read) begin
            next_st.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st          <= '0;
         st.irq_mask <= MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_reload_zero: assert property (@(posedge clk) disable iff (!nrst)
      (reload && st.ctrl.unit_enable) |=> st.cycle_counter == 16'h0000)
      else $error("counter did not reload");
   chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
      (tick && !reload && st.ctrl.unit_enable)
      |=> st.cycle_counter == $past(st.cycle_counter) + 16'h0001)
      else $error("counter did not step");
   chk_count_hold: assert property (@(posedge clk) disable iff (!nrst)
      (!tick && st.ctrl.unit_enable) |=> $stable(st.cycle_counter))
      else $error("counter moved without tick");
   chk_shadow_hold: assert property (@(posedge clk) disable iff (!nrst)
      !reload |=> $stable(st.duty_shadow))
      else $error("shadow duty changed mid cycle");
   chk_wave_cmp: assert property (@(posedge clk) disable iff (!nrst)
      st.ctrl.unit_enable |=> wave_out == ($past(cmp_hi)
         ^ $past(st.ctrl.output_polarity)))
      else $error("wave does not follow compare");
   chk_idle_level: assert property (@(posedge clk) disable iff (!nrst)
      !st.ctrl.unit_enable |=> wave_out == $past(st.ctrl.idle_level))
      else $error("idle level not driven");
   chk_buf_commit: assert property (@(posedge clk) disable iff (!nrst)
      (wr_hit && req.address == ADDR_DUTY_LO) |=> $stable(st.duty_value))
      else $error("duty applied before commit");
   chk_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
      (!st.ctrl.irq_enable && !adc_irq) |-> !shared_irq_line)
      else $error("interrupt without enable");
endmodule
`default_nettype wire

// file: logic/pwmg_pkg.sv
// Contract
// - Counter advances per prescaled tick
// - Counter reloads zero after reaching period
// - Cycle lasts (prescale+1)*(period+1) clocks
// - Normal polarity: low below duty, else high
// - Polarity bit inverts the output
// - Shadow duty refreshed only on reload
// - Flag set at every counter reload
// - Writing one clears the flag
// - Interrupt drives line shared with converter
// - Enable runs unit; disabled drives idle
// - Duty and period-low buffered until period-high
`default_nettype none
package pwmg_pkg;
   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [15:0] ADDR_CONTROL   = 16'ha028;
   localparam logic [15:0] ADDR_PERIOD_HI = 16'ha029;
   localparam logic [15:0] ADDR_PERIOD_LO = 16'ha02a;
   localparam logic [15:0] ADDR_DUTY_HI   = 16'ha02b;
   localparam logic [15:0] ADDR_DUTY_LO   = 16'ha02c;
   localparam logic [15:0] ADDR_IRQ_MASK  = 16'ha030;
   // -----------------------------------------------------------------
   // Control field positions
   // -----------------------------------------------------------------
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_PS_HI    = 6;
   localparam int BIT_PS_LO    = 4;
   localparam int BIT_IDLE     = 3;
   localparam int BIT_IRQ_EN   = 2;
   localparam int BIT_POLARITY = 1;
   localparam int BIT_FLAG     = 0;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [2:0]  PS_ZERO    = 3'h0;
   localparam logic [7:0]  MASK_RESET = 8'h01;

   // Control register contents
   typedef struct packed {
      logic       unit_enable;
      logic [2:0] prescale_select;
      logic       idle_level;
      logic       irq_enable;
      logic       output_polarity;
   } pwmg_ctrl_t;

   // Avalon-MM slave request
   typedef struct packed {
      logic        read;
      logic        write;
      logic [15:0] address;
      logic [31:0] writedata;
   } pwmg_bus_req_t;
endpackage
`default_nettype wire

// file: logic/pwmg_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module pwmg_prescaler
   import pwmg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       run,
   input  wire logic [2:0] divide_sel,
   output logic            tick
);
   typedef struct packed {
      logic [2:0] cnt;
   } pwmg_ps_state_t;

   pwmg_ps_state_t st;
   pwmg_ps_state_t next_st;

   // ----------------------------------------------------------------
   // Divide by divide_sel+1
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      tick    = 1'b0;
      if (!run) begin
         next_st.cnt = PS_ZERO;
      end else if (st.cnt >= divide_sel) begin
         next_st.cnt = PS_ZERO;
         tick        = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   chk_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
      (tick && run && divide_sel == 3'h1 && $stable(divide_sel))
      |=> !tick) else $error("prescale tick too early");
endmodule
`default_nettype wire

// file: logic/pwmg_irq.sv
`timescale 1ns/1ps
`default_nettype none
module pwmg_irq
   import pwmg_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic event_in,
   input  wire logic clear_in,
   input  wire logic gate_in,
   output logic      flag,
   output logic      irq
);
   typedef struct packed {
      logic flag;
   } pwmg_irq_state_t;

   pwmg_irq_state_t st;
   pwmg_irq_state_t next_st;

   // ----------------------------------------------------------------
   // Sticky flag; a set in the clear cycle wins
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (event_in) begin
         next_st.flag = 1'b1;
      end else if (clear_in) begin
         next_st.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flag = st.flag;
   assign irq  = st.flag & gate_in;

   chk_flag_set: assert property (@(posedge clk) disable iff (!nrst)
      event_in |=> flag) else $error("flag missed event");
   chk_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
      (clear_in && !event_in) |=> !flag) else $error("flag not cleared");
endmodule
`default_nettype wire

// file: test/tb_pwm16_generator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pwm16_generator
   import pwmg_pkg::*;
;
   // ----------------------------------------------------------
   // Signals
   // ----------------------------------------------------------
   logic        clk, nrst, rd, wr, adc_irq, wreq, wave, irq;
   logic [15:0] addr, per, dut;
   logic [31:0] wdata, rdata;
   logic [1:0]  resp;
   logic [2:0]  ps;
   logic [9:0]  expq[$];
   int          miscompares, checked, p, h, len;

   pwmg_top u_dut (
      .clk             (clk),
      .nrst            (nrst),
      .avs_address     (addr),
      .avs_read        (rd),
      .avs_write       (wr),
      .avs_writedata   (wdata),
      .avs_byteenable  (4'hf),
      .avs_readdata    (rdata),
      .avs_waitrequest (wreq),
      .avs_response    (resp),
      .adc_irq         (adc_irq),
      .wave_out        (wave),
      .shared_irq_line (irq)
   );

   // ----------------------------------------------------------
   // Clock, checks and bus tasks
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report;
      $display("miscompares=%0d checked=%0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic bad(input string m);
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
   endtask

   task automatic cmp_rd(input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e) bad($sformatf("read exp %h got %h", e, g));
   endtask

   task automatic cmp_lv(input logic e, input logic g);
      checked++;
      if (g !== e) bad($sformatf("level exp %b got %b", e, g));
   endtask

   task automatic cmp_n(input int e, input int g);
      checked++;
      if (g != e) bad($sformatf("count exp %0d got %0d", e, g));
   endtask

   function automatic logic [7:0] cb(input logic e, input logic [2:0] s,
      input logic i, input logic ie, input logic pl, input logic f);
      return {e, s, i, ie, pl, f};
   endfunction

   // Holds request until waitrequest sampled low; read note queued
   task automatic bus(input logic w, input logic [15:0] a,
                      input logic [7:0] d, input logic [9:0] e);
      int n;
      n = 0;
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= {24'h0, d};
      if (!w) expq.push_back(e);
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      if (n >= 50) bad("no answer");
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   // Read data is judged at the edge that completes the read
   always @(posedge clk) begin
      if (rd === 1'b1 && wreq === 1'b0 && expq.size() > 0) begin
         cmp_rd(expq.pop_front(), {resp, rdata[7:0]});
      end
   end

   // Clocks from one rising edge of the output to the next
   task automatic meas(output int pc, output int hc);
      logic last, rise;
      pc = 0;
      hc = 0;
      last = 1'b1;
      do begin
         @(posedge clk);
         rise = (wave === 1'b1 && last === 1'b0);
         last = wave;
         pc++;
      end while (!rise && pc < 4000);
      pc = 0;
      do begin
         @(posedge clk);
         rise = (wave === 1'b1 && last === 1'b0);
         last = wave;
         hc += (wave === 1'b1);
         pc++;
      end while (!rise && pc < 4000);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad("timeout");
      final_report;
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      void'($urandom(13767));
      {nrst, rd, wr, adc_irq, addr, wdata} = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) bus(1'b0, ADDR_CONTROL + 16'(i), 8'h00, 10'h000);
      bus(1'b0, ADDR_IRQ_MASK, 8'h00, {2'b00, MASK_RESET});
      bus(1'b0, 16'ha02d, 8'h00, 10'h200);
      ps = 3'($urandom % 3);
      per = 16'(3 + $urandom % 5);
      dut = 16'(1 + $urandom % per);
      // Staged bytes must not show before the period high byte
      bus(1'b1, ADDR_DUTY_LO, dut[7:0], 10'h000);
      bus(1'b1, ADDR_DUTY_HI, dut[15:8], 10'h000);
      bus(1'b1, ADDR_PERIOD_LO, per[7:0], 10'h000);
      bus(1'b0, ADDR_PERIOD_LO, 8'h00, 10'h000);
      bus(1'b0, ADDR_DUTY_LO, 8'h00, 10'h000);
      bus(1'b1, ADDR_PERIOD_HI, per[15:8], 10'h000);
      bus(1'b0, ADDR_PERIOD_LO, 8'h00, {2'b00, per[7:0]});
      bus(1'b0, ADDR_DUTY_LO, 8'h00, {2'b00, dut[7:0]});
      // First cycle may still use the old shadow duty, so skip it
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, ADDR_CONTROL, cb(1'b1, ps, 1'b0, 1'b1, k[0], 1'b1), 10'h000);
         meas(p, h);
         meas(p, h);
         len = (ps + 1) * (per + 1);
         cmp_n(len, p);
         cmp_n(k ? (ps + 1) * dut : len - (ps + 1) * dut, h);
      end
      cmp_lv(1'b1, irq);
      bus(1'b0, ADDR_CONTROL, 8'h00, {2'b00, cb(1'b1, ps, 1'b0, 1'b1, 1'b1, 1'b1)});
      bus(1'b1, ADDR_IRQ_MASK, 8'h00, 10'h000);
      cmp_lv(1'b0, irq);
      bus(1'b1, ADDR_IRQ_MASK, 8'h01, 10'h000);
      cmp_lv(1'b1, irq);
      bus(1'b1, ADDR_CONTROL, cb(1'b1, ps, 1'b0, 1'b0, 1'b1, 1'b0), 10'h000);
      cmp_lv(1'b0, irq);
      // Disabled: output rests at the idle level, flag cleared
      for (int i = 0; i < 2; i++) begin
         // Second write clears the flag once no reload can race it
         bus(1'b1, ADDR_CONTROL, cb(1'b0, ps, i[0], 1'b1, 1'b0, 1'b1), 10'h000);
         bus(1'b1, ADDR_CONTROL, cb(1'b0, ps, i[0], 1'b1, 1'b0, 1'b1), 10'h000);
         repeat (3) @(posedge clk);
         cmp_lv(i[0], wave);
         cmp_lv(1'b0, irq);
         bus(1'b0, ADDR_CONTROL, 8'h00, {2'b00, cb(1'b0, ps, i[0], 1'b1, 1'b0, 1'b0)});
      end
      adc_irq <= 1'b1;
      repeat (2) @(posedge clk);
      cmp_lv(1'b1, irq);
      adc_irq <= 1'b0;
      @(posedge clk);
      final_report;
   end
endmodule
`default_nettype wire
